// file: common/scc_params.svh
// Purpose: Constants of the serializer control and status block.
// Assumes: clk_sys is the 40 MHz pixel clock.
// Notes: Addresses are register pointers seen over the serial control bus.
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH
`define SCC_ADDR_GENCFG 8'h03
`define SCC_ADDR_LINK 8'h0C
`define SCC_ADDR_PORTSEL 8'h1E
`define SCC_ADDR_INTCTL 8'hC6
`define SCC_ADDR_INTSTS 8'hC7
`define SCC_GENCFG_RST 8'h10
`define SCC_PORTSEL_RST 8'h01
`define SCC_GENCFG_FILT 4
`define SCC_PSEL_SECOND 1
`define SCC_PSEL_SECEN 2
`define SCC_INT_GLOBAL 5
`define SCC_INT_REMOTE 0
`define SCC_INT_LINK 1
`define SCC_STS_REMOTE 0
`define SCC_STS_LINK 1
`define SCC_I2C_MAIN 7'h0C
`define SCC_I2C_SECOND 7'h0D
`define SCC_FILT_PCLKS 3
`endif

// file: common/scc_pkg.sv
// Purpose: Types of the serializer control and status block.
// Assumes: Constants come from scc_params.svh.
// Notes: The whole block state is one packed struct.
`include "scc_params.svh"
package scc_pkg;
    // Serial control bus slave states, one-hot.
    typedef enum logic [4:0] {
        I2C_IDLE = 5'h01,
        I2C_RX = 5'h02,
        I2C_ACK = 5'h04,
        I2C_TX = 5'h08,
        I2C_RACK = 5'h10
    } scc_i2c_t;

    // Complete register state of the block.
    typedef struct packed {
        logic sclS1, sclS2, sclPrev, sdaS1, sdaS2, sdaPrev, pdS1, pdS2;
        logic [1:0] remS1, remS2, remPrev, linkS1, linkS2, linkPrev;
        scc_i2c_t i2cState;
        logic [3:0] bitCnt;
        logic [7:0] shift, regPtr, generalConfig, portSelect;
        logic [1:0] phase;
        logic isRead, useSecond, sdaDrive, intOutN, vsOut;
        logic [1:0][7:0] intCtrl, intStatus;
        logic [1:0] mirror, filtOut;
        logic [1:0][1:0] filtCnt;
    } scc_state_t;
endpackage : scc_pkg

// file: rtl/scc_serializer_ctrl.sv
// Purpose: Port-routed registers, control signal filter, power-down and link interrupts.
// Assumes: clk_sys is the pixel clock; bus, link and power-down pins are asynchronous.
// Notes: The serial control bus clock is sampled, not used as a clock.
`timescale 1ns/1ps
`include "scc_params.svh"
module scc_serializer_ctrl
    import scc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic powerDownInputN,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic horizontalSyncIn,
    input wire logic verticalSyncIn,
    input wire logic dataEnableVideoIn,
    output logic horizontalSyncOut,
    output logic verticalSyncOut,
    output logic dataEnableVideoOut,
    input wire logic [1:0] cableDetect,
    input wire logic [1:0] remoteInterruptInputN,
    output logic interruptOutputN,
    output logic [1:0] remoteInterruptMirror,
    output logic deviceActive
);
    // Present and next state.
    scc_state_t cur;
    scc_state_t nxt;

    // Bus pin events, taken from the second and third sampling stages.
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    // Register routing.
    logic secEn;
    logic rdPort;
    logic [1:0] wrMask;
    logic matchMain;
    logic matchSec;
    // One-cycle strobes of the bus slave.
    logic loadRd;
    logic wrEn;
    logic [7:0] rdData;
    // Per-port events.
    logic [1:0] remFall;
    logic [1:0] remEn;
    logic [1:0] linkChg;
    logic [1:0] rdClear;
    logic filtOn;

    // Read decode; shared by both read-load paths of the slave.
    function automatic logic [7:0] regRead(
        input logic [7:0] ptr,
        input logic port,
        input scc_state_t s
    );
        logic [7:0] val;
        val = 8'h00;
        unique case (ptr)
            // Shared registers answer regardless of port select.
            `SCC_ADDR_GENCFG: val = s.generalConfig;
            `SCC_ADDR_PORTSEL: val = s.portSelect;
            // One fault flag per port, whatever the fault kind.
            `SCC_ADDR_LINK: val = {7'h00, s.linkS2[port]};
            `SCC_ADDR_INTCTL: val = s.intCtrl[port];
            `SCC_ADDR_INTSTS: val = s.intStatus[port];
            default: val = 8'h00;
        endcase
        return val;
    endfunction : regRead

    // Edge and condition detection on the synchronised bus pins.
    assign sclRise = cur.sclS2 & ~cur.sclPrev;
    assign sclFall = ~cur.sclS2 & cur.sclPrev;
    assign startSeen = cur.sclS2 & cur.sclPrev & cur.sdaPrev & ~cur.sdaS2;
    assign stopSeen = cur.sclS2 & cur.sclPrev & ~cur.sdaPrev & cur.sdaS2;

    // Port routing: the second address overrides the select bits.
    assign secEn = cur.portSelect[`SCC_PSEL_SECEN];
    assign rdPort = secEn ? cur.useSecond : cur.portSelect[`SCC_PSEL_SECOND];
    assign wrMask = secEn ? {cur.useSecond, ~cur.useSecond} : cur.portSelect[1:0];
    assign matchMain = cur.shift[7:1] == `SCC_I2C_MAIN;
    assign matchSec = secEn && (cur.shift[7:1] == `SCC_I2C_SECOND);

    // A data byte is fetched after the address ack or an acked read byte.
    assign loadRd = sclFall && ((cur.i2cState == I2C_ACK && cur.isRead) ||
                    cur.i2cState == I2C_RACK);
    assign wrEn = sclFall && cur.i2cState == I2C_RX && cur.bitCnt == 4'h8 &&
                  cur.phase == 2'h2 && !cur.isRead;
    assign rdData = regRead(cur.regPtr, rdPort, cur);
    assign filtOn = cur.generalConfig[`SCC_GENCFG_FILT];

    // Per-port event detection, all on synchronised levels.
    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_port
            // Falling edge only: a held low level cannot re-raise.
            assign remFall[gp] = cur.linkS2[gp] & cur.remPrev[gp] & ~cur.remS2[gp];
            assign remEn[gp] = cur.intCtrl[gp][`SCC_INT_GLOBAL] &
                               cur.intCtrl[gp][`SCC_INT_REMOTE];
            assign linkChg[gp] = (cur.linkS2[gp] ^ cur.linkPrev[gp]) &
                                 cur.intCtrl[gp][`SCC_INT_GLOBAL] &
                                 cur.intCtrl[gp][`SCC_INT_LINK];
            assign rdClear[gp] = loadRd && cur.regPtr == `SCC_ADDR_INTSTS &&
                                 rdPort == 1'(gp);
        end
    endgenerate

    // Next-state logic for the whole block.
    always_comb begin
        nxt = cur;
        // Two-stage synchronisers; the first stage feeds only the second.
        nxt.sclS1 = sclIn;
        nxt.sclS2 = cur.sclS1;
        nxt.sclPrev = cur.sclS2;
        nxt.sdaS1 = sdaIn;
        nxt.sdaS2 = cur.sdaS1;
        nxt.sdaPrev = cur.sdaS2;
        nxt.pdS1 = powerDownInputN;
        nxt.pdS2 = cur.pdS1;
        nxt.remS1 = remoteInterruptInputN;
        nxt.remS2 = cur.remS1;
        nxt.remPrev = cur.remS2;
        nxt.linkS1 = cableDetect;
        nxt.linkS2 = cur.linkS1;
        nxt.linkPrev = cur.linkS2;

        // Start and stop win over any bit in flight.
        if (startSeen) begin
            nxt.i2cState = I2C_RX;
            nxt.bitCnt = 4'h0;
            nxt.phase = 2'h0;
            nxt.sdaDrive = 1'b0;
        end else if (stopSeen) begin
            nxt.i2cState = I2C_IDLE;
            nxt.sdaDrive = 1'b0;
        end else begin
            unique case (cur.i2cState)
                I2C_IDLE: begin
                    // Wait for a start condition.
                    nxt.sdaDrive = 1'b0;
                end
                I2C_RX: begin
                    // Bits are sampled on the rising clock edge.
                    if (sclRise && cur.bitCnt < 4'h8) begin
                        nxt.shift = {cur.shift[6:0], cur.sdaS2};
                        nxt.bitCnt = cur.bitCnt + 4'h1;
                    end else if (sclFall && cur.bitCnt == 4'h8) begin
                        nxt.sdaDrive = 1'b1;
                        nxt.i2cState = I2C_ACK;
                        unique case (cur.phase)
                            2'h0: begin
                                // Address byte; silent release on a mismatch.
                                if (matchMain || matchSec) begin
                                    nxt.useSecond = matchSec;
                                    nxt.isRead = cur.shift[0];
                                    nxt.phase = cur.shift[0] ? 2'h2 : 2'h1;
                                end else begin
                                    nxt.sdaDrive = 1'b0;
                                    nxt.i2cState = I2C_IDLE;
                                end
                            end
                            2'h1: begin
                                // Register pointer byte.
                                nxt.regPtr = cur.shift;
                                nxt.phase = 2'h2;
                            end
                            default: begin
                                // Data byte, written below; pointer advances.
                                nxt.regPtr = cur.regPtr + 8'h01;
                            end
                        endcase
                    end
                end
                I2C_ACK: begin
                    // Ack held low until the next falling clock edge, one full clock period.
                    if (sclFall) begin
                        nxt.sdaDrive = 1'b0;
                        nxt.bitCnt = 4'h0;
                        if (!cur.isRead) begin
                            nxt.i2cState = I2C_RX;
                        end
                    end
                end
                I2C_TX: begin
                    // Data shifts out on falling edges, open-drain.
                    if (sclFall) begin
                        if (cur.bitCnt == 4'h7) begin
                            nxt.sdaDrive = 1'b0;
                            nxt.i2cState = I2C_RACK;
                        end else begin
                            nxt.bitCnt = cur.bitCnt + 4'h1;
                            nxt.shift = {cur.shift[6:0], 1'b0};
                            nxt.sdaDrive = ~cur.shift[6];
                        end
                    end
                end
                I2C_RACK: begin
                    // A master nack ends the read.
                    if (sclRise && cur.sdaS2) begin
                        nxt.i2cState = I2C_IDLE;
                    end
                end
                default: begin
                    // Illegal code: recover to idle.
                    nxt.i2cState = I2C_IDLE;
                    nxt.sdaDrive = 1'b0;
                end
            endcase
        end

        // Fetch of the next read byte; status reads are destructive.
        if (loadRd) begin
            nxt.i2cState = I2C_TX;
            nxt.shift = rdData;
            nxt.sdaDrive = ~rdData[7];
            nxt.bitCnt = 4'h0;
            nxt.regPtr = cur.regPtr + 8'h01;
        end

        // Register writes; read-only locations ignore them.
        if (wrEn) begin
            unique case (cur.regPtr)
                `SCC_ADDR_GENCFG: nxt.generalConfig = cur.shift;
                `SCC_ADDR_PORTSEL: nxt.portSelect = {5'h00, cur.shift[2:0]};
                `SCC_ADDR_INTCTL: begin
                    for (int p = 0; p < 2; p++) begin
                        if (wrMask[p]) begin
                            nxt.intCtrl[p] = cur.shift;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Status clear first, so an event in the same cycle survives.
        for (int p = 0; p < 2; p++) begin
            if (rdClear[p]) begin
                nxt.intStatus[p] = 8'h00;
            end
            if (remFall[p] && remEn[p]) begin
                nxt.intStatus[p][`SCC_STS_REMOTE] = 1'b1;
            end
            if (linkChg[p]) begin
                nxt.intStatus[p][`SCC_STS_LINK] = 1'b1;
            end
            // Mirror is a plain level; forced high without link.
            nxt.mirror[p] = cur.linkS2[p] ? cur.remS2[p] : 1'b1;
        end

        // Minimum pulse width filter for horizontal sync and data enable.
        for (int c = 0; c < 2; c++) begin
            logic din;
            din = (c == 0) ? horizontalSyncIn : dataEnableVideoIn;
            if (!filtOn) begin
                nxt.filtOut[c] = din;
                nxt.filtCnt[c] = 2'h0;
            end else if (din == cur.filtOut[c]) begin
                nxt.filtCnt[c] = 2'h0;
            end else if (cur.filtCnt[c] == 2'(`SCC_FILT_PCLKS - 1)) begin
                nxt.filtOut[c] = din;
                nxt.filtCnt[c] = 2'h0;
            end else begin
                nxt.filtCnt[c] = cur.filtCnt[c] + 2'h1;
            end
        end
        // Vertical sync is slow by contract and passes unfiltered.
        nxt.vsOut = verticalSyncIn;

        // Power-down: control and status registers return to defaults; the bus slave returns to idle.
        if (!cur.pdS2) begin
            nxt.generalConfig = `SCC_GENCFG_RST;
            nxt.portSelect = `SCC_PORTSEL_RST;
            nxt.intCtrl = '0;
            nxt.intStatus = '0;
            nxt.i2cState = I2C_IDLE;
            nxt.sdaDrive = 1'b0;
        end
        // Interrupt output is low while anything is pending.
        nxt.intOutN = ~(|nxt.intStatus[0] | |nxt.intStatus[1]);
    end

    // State register; reset loads constants only.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cur <= '0;
            cur.i2cState <= I2C_IDLE;
            cur.generalConfig <= `SCC_GENCFG_RST;
            cur.portSelect <= `SCC_PORTSEL_RST;
            cur.intOutN <= 1'b1;
            cur.mirror <= 2'h3;
            // Remote lines start at their idle high level, like the pins at rest.
            cur.remS1 <= 2'h3;
            cur.remS2 <= 2'h3;
            cur.remPrev <= 2'h3;
        end else begin
            cur <= nxt;
        end
    end

    // Outputs straight from flip-flops, except sdaOut, which is tied low.
    assign sdaOut = 1'b0;
    assign sdaOe = cur.sdaDrive;
    assign horizontalSyncOut = cur.filtOut[0];
    assign dataEnableVideoOut = cur.filtOut[1];
    assign verticalSyncOut = cur.vsOut;
    assign interruptOutputN = cur.intOutN;
    assign remoteInterruptMirror = cur.mirror;
    assign deviceActive = cur.pdS2;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_remote_raise: assert property ((remFall[0] && remEn[0] && cur.pdS2) |=>
        (!interruptOutputN && cur.intStatus[0][`SCC_STS_REMOTE]))
        else $error("remote fall did not raise interrupt");
    a_no_relevel: assert property ((!cur.intStatus[0][`SCC_STS_REMOTE] && !remFall[0])
        |=> !cur.intStatus[0][`SCC_STS_REMOTE])
        else $error("remote pending set without falling edge");
    a_read_clear: assert property ((rdClear[0] && !remFall[0] && !linkChg[0] &&
        !remFall[1] && !linkChg[1] && cur.intStatus[1] == 8'h00) |=> interruptOutputN)
        else $error("status read did not release interrupt");
    a_mirror_down: assert property (!cur.linkS2[1] |=> remoteInterruptMirror[1])
        else $error("mirror low without link");
    a_mirror_follow: assert property (cur.linkS2[0] |=>
        remoteInterruptMirror[0] == $past(cur.remS2[0]))
        else $error("mirror does not follow remote level");
    a_filter_min: assert property (($changed(horizontalSyncOut) && $past(filtOn, 1) &&
        $past(filtOn, 2) && $past(filtOn, 3)) |-> ($past(horizontalSyncIn, 1) ==
        horizontalSyncOut && $past(horizontalSyncIn, 2) == horizontalSyncOut &&
        $past(horizontalSyncIn, 3) == horizontalSyncOut))
        else $error("short sync pulse passed the filter");
    a_filter_off: assert property (!filtOn |=> dataEnableVideoOut == $past(dataEnableVideoIn))
        else $error("unfiltered enable not passed");
    a_dual_write: assert property ((wrEn && cur.regPtr == `SCC_ADDR_INTCTL &&
        wrMask == 2'h3) |=> cur.intCtrl[0] == cur.intCtrl[1])
        else $error("dual port write left copies unequal");
    a_second_route: assert property ((wrEn && secEn && cur.useSecond && cur.pdS2 &&
        cur.regPtr == `SCC_ADDR_INTCTL) |=> (cur.intCtrl[1] == $past(cur.shift) &&
        cur.intCtrl[0] == $past(cur.intCtrl[0])))
        else $error("second address write misrouted");
    a_pd_reset: assert property (!cur.pdS2 |=> (cur.generalConfig == `SCC_GENCFG_RST &&
        cur.intCtrl == '0 && interruptOutputN))
        else $error("power-down did not reset registers");

    c_remote_int: cover property (remFall[0] && remEn[0] ##1 !interruptOutputN);
    c_status_read: cover property (rdClear[0] && !interruptOutputN);
    c_second_addr: cover property (wrEn && secEn && cur.useSecond);
    c_short_drop: cover property (filtOn && horizontalSyncIn != horizontalSyncOut
        ##1 horizontalSyncIn == horizontalSyncOut);
endmodule : scc_serializer_ctrl

// file: tb/scc_host_model.sv
// Purpose: Host controller model that masters the serial control bus.
// Assumes: Eight clock low and high phases; the device answers within them.
// Notes: The data line is open drain, so it idles high through the pull-up.
`timescale 1ns/1ps
module scc_host_model (
    input wire logic clk_sys,
    input wire logic sdaOe,
    input wire logic sdaOut,
    output logic sclIn,
    output wire logic sdaIn
);
    logic pullLow; // High while the host pulls the data line low.
    // Wired-AND of both parties; released means high, never the last value.
    assign sdaIn = ~pullLow & (sdaOe ? sdaOut : 1'b1);
    initial begin
        sclIn = 1'b1;
        pullLow = 1'b0;
    end
    // Whole clocks only, so every change lands just after an edge.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    // Data changes only while the clock is low, and is sampled mid-high.
    task automatic bitIo(input logic b, output logic got);
        sclIn <= 1'b0;
        tick(2);
        pullLow <= ~b;
        tick(6);
        sclIn <= 1'b1;
        tick(4);
        got = sdaIn;
        tick(4);
    endtask : bitIo
    // A start is the data line falling while the clock stays high.
    task automatic start();
        pullLow <= 1'b1;
        tick(8);
    endtask : start
    // A stop is the data line rising while the clock stays high.
    task automatic stop();
        sclIn <= 1'b0;
        tick(2);
        pullLow <= 1'b1;
        tick(6);
        sclIn <= 1'b1;
        tick(8);
        pullLow <= 1'b0;
        tick(8);
    endtask : stop
    // Eight bits most significant first, then the acknowledge bit.
    task automatic byteIo(input logic [7:0] tx, input logic ackBit,
                          output logic [7:0] rx, output logic ackSeen);
        logic a;
        for (int i = 7; i >= 0; i--) bitIo(tx[i], rx[i]);
        bitIo(ackBit, a);
        ackSeen = ~a;
    endtask : byteIo
endmodule : scc_host_model

// file: tb/tb_serializer_control_status.sv
// Purpose: Self-checking bench of the serializer control and status block.
// Assumes: Inputs change at rising edges; the host model owns the bus pins.
// Notes: Power-down is held only a few clocks to keep the run short.
`timescale 1ns/1ps
`include "scc_params.svh"
module tb_serializer_control_status;
    import scc_pkg::*;
    localparam logic [6:0] M = `SCC_I2C_MAIN;
    localparam logic [6:0] S = `SCC_I2C_SECOND;
    localparam logic [7:0] IC = `SCC_ADDR_INTCTL;
    localparam logic [7:0] GC = `SCC_ADDR_GENCFG;
    localparam logic [7:0] PS = `SCC_ADDR_PORTSEL;
    // One register case: select, write, reselect, read back.
    typedef struct packed {
        logic [7:0] psel;
        logic [6:0] dev;
        logic [7:0] ptr, wd, rpsel;
        logic [6:0] rdev;
        logic [7:0] exp;
    } scc_row_t;
    scc_row_t rows [9] = '{'{8'h01, M, IC, 8'h21, 8'h01, M, 8'h21},
        '{8'h02, M, IC, 8'h20, 8'h01, M, 8'h21}, '{8'h02, M, IC, 8'h20, 8'h02, M, 8'h20},
        '{8'h03, M, IC, 8'h01, 8'h03, M, 8'h01}, '{8'h02, M, IC, 8'h22, 8'h03, M, 8'h22},
        '{8'h01, M, IC, 8'h20, 8'h03, M, 8'h22}, '{8'h02, M, GC, 8'h00, 8'h01, M, 8'h00},
        '{8'h05, S, IC, 8'h21, 8'h05, M, 8'h20}, '{8'h06, M, IC, 8'h01, 8'h06, S, 8'h21}};
    logic clk_sys, reset_n, pdN, sclIn, sdaIn, sdaOe, hsIn, vsIn, deIn, hsOut, vsOut, deOut;
    logic irqN, active, k, sdaOut;
    logic [1:0] cable, remN, mirror;
    logic [7:0] rd;
    int mismatches = 0;
    int comparisons = 0;
    scc_serializer_ctrl i_scc_serializer_ctrl (.clk_sys(clk_sys), .reset_n(reset_n),
        .powerDownInputN(pdN), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .horizontalSyncIn(hsIn), .verticalSyncIn(vsIn), .dataEnableVideoIn(deIn),
        .horizontalSyncOut(hsOut), .verticalSyncOut(vsOut), .dataEnableVideoOut(deOut),
        .cableDetect(cable), .remoteInterruptInputN(remN), .interruptOutputN(irqN),
        .remoteInterruptMirror(mirror), .deviceActive(active));
    scc_host_model i_scc_host_model (.clk_sys(clk_sys), .sdaOe(sdaOe), .sclIn(sclIn),
        .sdaIn(sdaIn), .sdaOut(sdaOut));
    // The 40 MHz pixel clock.
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic final_report();
        if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
            mismatches++;
        end
    endtask : check
    // A write with no data byte only moves the register pointer.
    task automatic regWr(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                         input logic wd);
        logic [7:0] rx;
        logic a;
        i_scc_host_model.start();
        i_scc_host_model.byteIo({dev, 1'b0}, 1'b1, rx, a);
        check({7'h00, a}, 8'h01, "address ack");
        i_scc_host_model.byteIo(ptr, 1'b1, rx, a);
        if (wd) i_scc_host_model.byteIo(d, 1'b1, rx, a);
        i_scc_host_model.stop();
    endtask : regWr
    // A read takes the current pointer, so the pointer is set first.
    task automatic regRd(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d);
        logic a;
        regWr(dev, ptr, 8'h00, 1'b0);
        i_scc_host_model.start();
        i_scc_host_model.byteIo({dev, 1'b1}, 1'b1, d, a);
        check({7'h00, a}, 8'h01, "read address ack");
        i_scc_host_model.byteIo(8'hFF, 1'b1, d, a);
        i_scc_host_model.stop();
    endtask : regRd
    // Drives horizontal sync and data enable high n clocks and records any output high.
    task automatic pulse(input int n, input logic exp);
        logic seenH, seenD;
        seenH = 1'b0;
        seenD = 1'b0;
        hsIn <= 1'b1;
        deIn <= 1'b1;
        for (int c = 0; c < n + 8; c++) begin
            @(posedge clk_sys);
            seenH |= hsOut;
            seenD |= deOut;
            if (c == n - 1) begin
                hsIn <= 1'b0;
                deIn <= 1'b0;
            end
        end
        check({6'h00, seenH, seenD}, {6'h00, exp, exp}, "sync filter");
        repeat (140) @(posedge clk_sys);
    endtask : pulse
    // Bounded wait for the interrupt output; running out ends the run.
    task automatic waitIrq(input logic lvl);
        int c;
        for (c = 0; c < 20 && irqN !== lvl; c++) @(posedge clk_sys);
        check({7'h00, irqN}, {7'h00, lvl}, "interrupt output");
        if (c == 20) final_report();
    endtask : waitIrq
    // Main sequence: reset, two bus address checks, register rows, then the hand-written cases.
    initial begin
        reset_n = 1'b0;
        pdN = 1'b1;
        {hsIn, vsIn, deIn} = 3'h0;
        cable = 2'b01;
        remN = 2'b01;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check({5'h00, irqN, mirror}, 8'h07, "reset outputs");
        check({7'h00, active}, 8'h01, "device active");
        regRd(M, 8'h55, rd);
        check(rd, 8'h00, "unmapped read");
        i_scc_host_model.start();
        i_scc_host_model.byteIo({S, 1'b0}, 1'b1, rd, k);
        check({7'h00, k}, 8'h00, "second address off");
        i_scc_host_model.stop();
        foreach (rows[i]) begin
            regWr(M, PS, rows[i].psel, 1'b1);
            regWr(rows[i].dev, rows[i].ptr, rows[i].wd, 1'b1);
            regWr(M, PS, rows[i].rpsel, 1'b1);
            regRd(rows[i].rdev, rows[i].ptr, rd);
            check(rd, rows[i].exp, "register row");
        end
        pulse(1, 1'b1);
        pdN <= 1'b0;
        repeat (10) @(posedge clk_sys);
        check({7'h00, active}, 8'h00, "powered down");
        pdN <= 1'b1;
        repeat (6) @(posedge clk_sys);
        regRd(M, GC, rd);
        check(rd, `SCC_GENCFG_RST, "config default");
        regRd(M, PS, rd);
        check(rd, `SCC_PORTSEL_RST, "select default");
        pulse(2, 1'b0);
        pulse(3, 1'b1);
        check({7'h00, vsOut}, 8'h00, "vertical sync low");
        vsIn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check({7'h00, vsOut}, 8'h01, "vertical sync");
        regRd(M, `SCC_ADDR_LINK, rd);
        check(rd & 8'h01, 8'h01, "cable found");
        regWr(M, PS, 8'h02, 1'b1);
        regRd(M, `SCC_ADDR_LINK, rd);
        check(rd & 8'h01, 8'h00, "link fault");
        regWr(M, PS, 8'h01, 1'b1);
        regWr(M, IC, 8'h21, 1'b1);
        remN <= 2'b00;
        waitIrq(1'b0);
        check({6'h00, mirror}, 8'h02, "mirror low");
        regRd(M, `SCC_ADDR_INTSTS, rd);
        check(rd & 8'h01, 8'h01, "remote pending");
        waitIrq(1'b1);
        repeat (40) @(posedge clk_sys);
        check({7'h00, irqN}, 8'h01, "no new event");
        remN <= 2'b01;
        repeat (6) @(posedge clk_sys);
        check({6'h00, mirror}, 8'h03, "mirror follows");
        remN <= 2'b00;
        waitIrq(1'b0);
        regWr(M, IC, 8'h22, 1'b1);
        regRd(M, `SCC_ADDR_INTSTS, rd);
        check(rd, 8'h01, "pending before clear");
        waitIrq(1'b1);
        cable <= 2'b00;
        waitIrq(1'b0);
        check({6'h00, mirror}, 8'h03, "mirror unlinked");
        final_report();
    end
endmodule : tb_serializer_control_status
